// ===== rtl/acr_top.sv
`timescale 1ns/1ns
// Functional notes
// R1 - DAC clock from three-bit source select.
// R2 - ADC clock, same encoding, own select.
// R3 - Second internal clock from two-bit select.
// R4 - First internal clock, identical two-bit encoding.
// R5 - PLL taps: full or halved rates.
// R6 - Second PLL reference: crystal or master.
// R7 - First PLL reference: crystal or master.
// R8 - Receiver power-down bit high powers down.
// R9 - System clock one driven while bit low.
// R10 - System clock two driven while bit low.
// R11 - System clock three driven while bit low.
// R12 - System clock three: PLL or recovered clock.
// R13 - Reserved bits zero; switching without runts.
module acr_top
  import acr_pkg::*;
(
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Register port.
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Candidate clocks from pins and PLLs.
  input wire logic i_crystal_input,
  input wire logic i_master_clock_input,
  input wire logic i_pll_one_rate,
  input wire logic i_pll_two_rate_a,
  input wire logic i_pll_two_rate_b,
  input wire logic i_rx_pll_512fs,
  input wire logic i_rx_pll_256fs,
  input wire logic i_sys_one_src,
  input wire logic i_sys_two_src,
  input wire logic i_sys_three_pll_src,
  // Routed core and internal clocks.
  output logic o_dac_core_clk,
  output logic o_adc_core_clk,
  output logic o_first_internal_clock,
  output logic o_second_internal_clock,
  output logic o_internal_pll_clock_one,
  output logic o_internal_pll_clock_two,
  output logic o_pll_one_ref_clk,
  output logic o_pll_two_ref_clk,
  // System clock pins.
  output logic o_system_clock_out_one,
  output logic o_system_clock_out_one_oe,
  output logic o_system_clock_out_two,
  output logic o_system_clock_out_two_oe,
  output logic o_system_clock_out_three,
  output logic o_system_clock_out_three_oe,
  // Receiver power.
  output logic o_receiver_power_down
);

  // Address decode of a write, used for every register.
  function automatic logic wr_hit(input logic wr, input logic [6:0] addr, input logic [6:0] reg_addr);
    wr_hit = wr && (addr == reg_addr);
  endfunction

  // Control registers; only the defined bits hold state.
  logic [7:0] ctrl1_q;
  logic [7:0] conv_q;
  logic [7:0] tap_q;
  logic [7:0] ref_q;
  logic [7:0] gate_q;
  logic [7:0] ctrl1_d;
  logic [7:0] conv_d;
  logic [7:0] tap_d;
  logic [7:0] ref_d;
  logic [7:0] gate_d;

  // Read port registers.
  logic [7:0] rdata_q;
  logic rvalid_q;
  logic [7:0] rd_word;

  // Two-stage synchroniser of the candidate clocks and an edge delay.
  logic [ACR_NSRC-1:0] meta_q;
  logic [ACR_NSRC-1:0] sync_q;

  // Halved PLL taps: rates, their delayed copies and the toggles.
  logic [2:0] rate_s;
  logic [2:0] rate_dly_q;
  logic [2:0] half_q;

  // Output enables of the system clock pins.
  logic oe_one_q;
  logic oe_two_q;
  logic oe_three_q;

  // R13 masked writes: reserved bits never take a value.
  assign ctrl1_d = wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_PLL_CTRL1) ? (i_reg_wdata & ACR_MASK_PLL_CTRL1) : ctrl1_q;
  assign conv_d = wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_CONV) ? (i_reg_wdata & ACR_MASK_CONV) : conv_q;
  assign tap_d = wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_TAP) ? (i_reg_wdata & ACR_MASK_TAP) : tap_q;
  assign ref_d = wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_REF) ? (i_reg_wdata & ACR_MASK_REF) : ref_q;
  assign gate_d = wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_GATE) ? (i_reg_wdata & ACR_MASK_GATE) : gate_q;

  // Register writes.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ctrl1_q <= ACR_RST_REG;
      conv_q <= ACR_RST_REG;
      tap_q <= ACR_RST_REG;
      ref_q <= ACR_RST_REG;
      gate_q <= ACR_RST_REG;
    end else begin
      ctrl1_q <= ctrl1_d;
      conv_q <= conv_d;
      tap_q <= tap_d;
      ref_q <= ref_d;
      gate_q <= gate_d;
    end
  end

  // Read selection; an unmapped offset reads as zero.
  assign rd_word = (i_reg_addr == ACR_ADDR_PLL_CTRL1) ? ctrl1_q :
                   (i_reg_addr == ACR_ADDR_CONV) ? conv_q :
                   (i_reg_addr == ACR_ADDR_TAP) ? tap_q :
                   (i_reg_addr == ACR_ADDR_REF) ? ref_q :
                   (i_reg_addr == ACR_ADDR_GATE) ? gate_q : ACR_RST_REG;

  // Read data is captured and held until the next read.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_q <= ACR_RST_REG;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= i_reg_rd ? rd_word : rdata_q;
      rvalid_q <= i_reg_rd;
    end
  end

  assign o_reg_rdata = rdata_q;
  assign o_reg_rvalid = rvalid_q;

  // Every candidate clock is sampled here, so each must stay well below half
  // the system clock rate; faster sources alias and cannot be routed.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= {i_sys_three_pll_src, i_sys_two_src, i_sys_one_src, i_rx_pll_256fs, i_rx_pll_512fs,
                 i_pll_two_rate_b, i_pll_two_rate_a, i_pll_one_rate, i_master_clock_input, i_crystal_input};
      sync_q <= meta_q;
    end
  end

  // R5 halved taps toggle on each rising edge of their rate.
  assign rate_s = {sync_q[ACR_SRC_P2B], sync_q[ACR_SRC_P2A], sync_q[ACR_SRC_P1]};

  // Edge delay and divide-by-two toggles.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rate_dly_q <= '0;
      half_q <= '0;
    end else begin
      rate_dly_q <= rate_s;
      half_q <= half_q ^ (rate_s & ~rate_dly_q);
    end
  end

  // One runt-free switch per selected clock; candidate positions equal codes.
  acr_mux_if #(.SW(ACR_W1)) p1tap_if();
  acr_mux_if #(.SW(ACR_W2)) p2tap_if();
  acr_mux_if #(.SW(ACR_W3)) dac_if();
  acr_mux_if #(.SW(ACR_W3)) adc_if();
  acr_mux_if #(.SW(ACR_W2)) ic1_if();
  acr_mux_if #(.SW(ACR_W2)) ic2_if();
  acr_mux_if #(.SW(ACR_W1)) ref1_if();
  acr_mux_if #(.SW(ACR_W1)) ref2_if();
  acr_mux_if #(.SW(ACR_W1)) rx3_if();
  acr_mux_if #(.SW(ACR_W2)) route_if();
  acr_mux_if #(.SW(ACR_W1)) sys1_if();
  acr_mux_if #(.SW(ACR_W1)) sys2_if();
  acr_mux_if #(.SW(ACR_W1)) sys3_if();

  // Named candidates shared by several switches.
  wire logic xtal_s = sync_q[ACR_SRC_XTAL];
  wire logic mclk_s = sync_q[ACR_SRC_MCLK];
  wire logic ip1 = p1tap_if.clk_out;
  wire logic ip2 = p2tap_if.clk_out;

  // R5 PLL taps: full rate or the halved copy.
  assign p1tap_if.sel = tap_q[ACR_P1TAP_BIT];
  assign p1tap_if.src = {half_q[ACR_HALF_P1], rate_s[ACR_HALF_P1]};
  assign p2tap_if.sel = tap_q[ACR_P2TAP_LSB +: ACR_W2];
  assign p2tap_if.src = {half_q[ACR_HALF_P2B], rate_s[ACR_HALF_P2B], half_q[ACR_HALF_P2A], rate_s[ACR_HALF_P2A]};

  // R1 DAC source; codes six and seven fall back to the crystal.
  assign dac_if.sel = conv_q[ACR_DAC_LSB +: ACR_W3];
  assign dac_if.src = {xtal_s, xtal_s, sync_q[ACR_SRC_RX256], sync_q[ACR_SRC_RX512], ip2, ip1, mclk_s, xtal_s};
  // R2 ADC source with the same encoding.
  assign adc_if.sel = conv_q[ACR_ADC_LSB +: ACR_W3];
  assign adc_if.src = dac_if.src;

  // R4 first internal clock.
  assign ic1_if.sel = tap_q[ACR_IC1_LSB +: ACR_W2];
  assign ic1_if.src = {ip2, ip1, mclk_s, xtal_s};
  // R3 second internal clock.
  assign ic2_if.sel = conv_q[ACR_IC2_LSB +: ACR_W2];
  assign ic2_if.src = {ip2, ip1, mclk_s, xtal_s};

  // R7 first PLL reference.
  assign ref1_if.sel = ref_q[ACR_P1REF_BIT];
  assign ref1_if.src = {mclk_s, xtal_s};
  // R6 second PLL reference.
  assign ref2_if.sel = ref_q[ACR_P2REF_BIT];
  assign ref2_if.src = {mclk_s, xtal_s};

  // R12 recovered clock rate, then PLL or recovered; reserved codes give low.
  assign rx3_if.sel = ctrl1_q[ACR_RX3_RATE_BIT];
  assign rx3_if.src = {sync_q[ACR_SRC_RX256], sync_q[ACR_SRC_RX512]};
  assign route_if.sel = ctrl1_q[ACR_ROUTE_LSB +: ACR_W2];
  assign route_if.src = {rx3_if.clk_out, 1'b0, 1'b0, sync_q[ACR_SRC_SYS3]};

  // R9 gate one: code one parks the pin low, no earlier than its enable drops.
  assign sys1_if.sel = gate_q[ACR_SYS1_BIT];
  assign sys1_if.src = {1'b0, sync_q[ACR_SRC_SYS1]};
  // R10 gate two.
  assign sys2_if.sel = gate_q[ACR_SYS2_BIT];
  assign sys2_if.src = {1'b0, sync_q[ACR_SRC_SYS2]};
  // R11 gate three.
  assign sys3_if.sel = gate_q[ACR_SYS3_BIT];
  assign sys3_if.src = {1'b0, route_if.clk_out};

  acr_glitch_mux #(.SW(ACR_W1)) u_p1tap (.i_clk(i_clk), .i_rst(i_rst), .m(p1tap_if.mux));
  acr_glitch_mux #(.SW(ACR_W2)) u_p2tap (.i_clk(i_clk), .i_rst(i_rst), .m(p2tap_if.mux));
  acr_glitch_mux #(.SW(ACR_W3)) u_dac (.i_clk(i_clk), .i_rst(i_rst), .m(dac_if.mux));
  acr_glitch_mux #(.SW(ACR_W3)) u_adc (.i_clk(i_clk), .i_rst(i_rst), .m(adc_if.mux));
  acr_glitch_mux #(.SW(ACR_W2)) u_ic1 (.i_clk(i_clk), .i_rst(i_rst), .m(ic1_if.mux));
  acr_glitch_mux #(.SW(ACR_W2)) u_ic2 (.i_clk(i_clk), .i_rst(i_rst), .m(ic2_if.mux));
  acr_glitch_mux #(.SW(ACR_W1)) u_ref1 (.i_clk(i_clk), .i_rst(i_rst), .m(ref1_if.mux));
  acr_glitch_mux #(.SW(ACR_W1)) u_ref2 (.i_clk(i_clk), .i_rst(i_rst), .m(ref2_if.mux));
  acr_glitch_mux #(.SW(ACR_W1)) u_rx3 (.i_clk(i_clk), .i_rst(i_rst), .m(rx3_if.mux));
  acr_glitch_mux #(.SW(ACR_W2)) u_route (.i_clk(i_clk), .i_rst(i_rst), .m(route_if.mux));
  acr_glitch_mux #(.SW(ACR_W1)) u_sys1 (.i_clk(i_clk), .i_rst(i_rst), .m(sys1_if.mux));
  acr_glitch_mux #(.SW(ACR_W1)) u_sys2 (.i_clk(i_clk), .i_rst(i_rst), .m(sys2_if.mux));
  acr_glitch_mux #(.SW(ACR_W1)) u_sys3 (.i_clk(i_clk), .i_rst(i_rst), .m(sys3_if.mux));

  // The enables drop one cycle after the gate register changes, whatever the clock level,
  // so a pin can be released while its switch is still draining a high phase.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      oe_one_q <= 1'b0;
      oe_two_q <= 1'b0;
      oe_three_q <= 1'b0;
    end else begin
      oe_one_q <= ~gate_q[ACR_SYS1_BIT];
      oe_two_q <= ~gate_q[ACR_SYS2_BIT];
      oe_three_q <= ~gate_q[ACR_SYS3_BIT];
    end
  end

  // Routed clocks come straight from the switch flip-flops.
  assign o_dac_core_clk = dac_if.clk_out;
  assign o_adc_core_clk = adc_if.clk_out;
  assign o_first_internal_clock = ic1_if.clk_out;
  assign o_second_internal_clock = ic2_if.clk_out;
  assign o_internal_pll_clock_one = ip1;
  assign o_internal_pll_clock_two = ip2;
  assign o_pll_one_ref_clk = ref1_if.clk_out;
  assign o_pll_two_ref_clk = ref2_if.clk_out;
  assign o_system_clock_out_one = sys1_if.clk_out;
  assign o_system_clock_out_two = sys2_if.clk_out;
  assign o_system_clock_out_three = sys3_if.clk_out;
  assign o_system_clock_out_one_oe = oe_one_q;
  assign o_system_clock_out_two_oe = oe_two_q;
  assign o_system_clock_out_three_oe = oe_three_q;
  // R8 receiver power-down straight from its register bit.
  assign o_receiver_power_down = gate_q[ACR_RXPD_BIT];

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  // A gate write followed by a quiet cycle.
  sequence s_gate_write;
    wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_GATE) ##1 !wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_GATE);
  endsequence

  a_rx_power_down: assert property (wr_hit(i_reg_wr, i_reg_addr, ACR_ADDR_GATE) |=> // R8
      o_receiver_power_down == $past(i_reg_wdata[ACR_RXPD_BIT]))
    else $error("Receiver power-down does not follow its bit.");
  a_sys_one_oe: assert property (s_gate_write |=> // R9
      o_system_clock_out_one_oe == !$past(i_reg_wdata[ACR_SYS1_BIT], 2))
    else $error("System clock one enable wrong.");
  a_sys_two_oe: assert property (s_gate_write |=> // R10
      o_system_clock_out_two_oe == !$past(i_reg_wdata[ACR_SYS2_BIT], 2))
    else $error("System clock two enable wrong.");
  a_sys_three_oe: assert property (s_gate_write |=> // R11
      o_system_clock_out_three_oe == !$past(i_reg_wdata[ACR_SYS3_BIT], 2))
    else $error("System clock three enable wrong.");
  a_dac_fallback: assert property (dac_if.locked && dac_if.sel == ACR_CK3_ALT6 |=> // R1
      o_dac_core_clk == $past(xtal_s))
    else $error("DAC clock code six is not the crystal.");
  a_adc_fallback: assert property (adc_if.locked && adc_if.sel == ACR_CK3_ALT7 |=> // R2
      o_adc_core_clk == $past(xtal_s))
    else $error("ADC clock code seven is not the crystal.");
  a_ic_two_master: assert property (ic2_if.locked && ic2_if.sel == ACR_CK2_MCLK |=> // R3
      o_second_internal_clock == $past(mclk_s))
    else $error("Second internal clock is not the master clock.");
  a_ic_one_pll: assert property (ic1_if.locked && ic1_if.sel == ACR_CK2_PLL1 |=> // R4
      o_first_internal_clock == $past(ip1))
    else $error("First internal clock is not PLL clock one.");
  a_tap_b_half: assert property (p2tap_if.locked && p2tap_if.sel == ACR_TAP_B_HALF |=> // R5
      o_internal_pll_clock_two == $past(half_q[ACR_HALF_P2B]))
    else $error("PLL two tap is not rate B halved.");
  a_ref_two_mclk: assert property (ref2_if.locked && ref2_if.sel == ACR_REF_MCLK |=> // R6
      o_pll_two_ref_clk == $past(mclk_s))
    else $error("PLL two reference is not the master clock.");
  a_ref_one_xtal: assert property (ref1_if.locked && ref1_if.sel == ACR_REF_XTAL |=> // R7
      o_pll_one_ref_clk == $past(xtal_s))
    else $error("PLL one reference is not the crystal.");
  a_route_reserved: assert property (route_if.locked && route_if.sel == ACR_ROUTE_RSV1 |=> !route_if.clk_out) // R12
    else $error("Reserved routing code passes a clock.");
  a_reserved_zero: assert property (i_reg_rd && i_reg_addr == ACR_ADDR_TAP |=> // R13
      (o_reg_rdata & ~ACR_MASK_TAP) == ACR_RST_REG)
    else $error("Reserved bits do not read as zero.");

endmodule

// ===== rtl/acr_pkg.sv
package acr_pkg;

  // Register offsets on the control port.
  localparam logic [6:0] ACR_ADDR_PLL_CTRL1 = 7'h74;
  localparam logic [6:0] ACR_ADDR_CONV = 7'h76;
  localparam logic [6:0] ACR_ADDR_TAP = 7'h77;
  localparam logic [6:0] ACR_ADDR_REF = 7'h78;
  localparam logic [6:0] ACR_ADDR_GATE = 7'h7A;

  // Bits that hold state; all others read as zero and ignore writes.
  localparam logic [7:0] ACR_MASK_PLL_CTRL1 = 8'hC1;
  localparam logic [7:0] ACR_MASK_CONV = 8'hFF;
  localparam logic [7:0] ACR_MASK_TAP = 8'h1F;
  localparam logic [7:0] ACR_MASK_REF = 8'hC0;
  localparam logic [7:0] ACR_MASK_GATE = 8'h37;

  // Reset values of the registers.
  localparam logic [7:0] ACR_RST_REG = 8'h00;

  // Field widths.
  localparam int ACR_W1 = 1;
  localparam int ACR_W2 = 2;
  localparam int ACR_W3 = 3;

  // Field positions.
  localparam int ACR_DAC_LSB = 5;
  localparam int ACR_ADC_LSB = 2;
  localparam int ACR_IC2_LSB = 0;
  localparam int ACR_IC1_LSB = 3;
  localparam int ACR_P2TAP_LSB = 1;
  localparam int ACR_P1TAP_BIT = 0;
  localparam int ACR_P2REF_BIT = 7;
  localparam int ACR_P1REF_BIT = 6;
  localparam int ACR_RXPD_BIT = 5;
  localparam int ACR_SYS1_BIT = 2;
  localparam int ACR_SYS2_BIT = 1;
  localparam int ACR_SYS3_BIT = 0;
  localparam int ACR_ROUTE_LSB = 6;
  localparam int ACR_RX3_RATE_BIT = 0;

  // Converter clock select codes.
  localparam logic [2:0] ACR_CK3_XTAL = 3'h0;
  localparam logic [2:0] ACR_CK3_MCLK = 3'h1;
  localparam logic [2:0] ACR_CK3_PLL1 = 3'h2;
  localparam logic [2:0] ACR_CK3_PLL2 = 3'h3;
  localparam logic [2:0] ACR_CK3_RX512 = 3'h4;
  localparam logic [2:0] ACR_CK3_RX256 = 3'h5;
  localparam logic [2:0] ACR_CK3_ALT6 = 3'h6;
  localparam logic [2:0] ACR_CK3_ALT7 = 3'h7;

  // Internal clock select codes.
  localparam logic [1:0] ACR_CK2_XTAL = 2'h0;
  localparam logic [1:0] ACR_CK2_MCLK = 2'h1;
  localparam logic [1:0] ACR_CK2_PLL1 = 2'h2;
  localparam logic [1:0] ACR_CK2_PLL2 = 2'h3;

  // PLL tap, reference and routing codes.
  localparam logic [1:0] ACR_TAP_B_HALF = 2'h3;
  localparam logic ACR_REF_XTAL = 1'b0;
  localparam logic ACR_REF_MCLK = 1'b1;
  localparam logic [1:0] ACR_ROUTE_RSV1 = 2'h1;

  // Positions of the candidate clocks in the synchroniser vector.
  localparam int ACR_SRC_XTAL = 0;
  localparam int ACR_SRC_MCLK = 1;
  localparam int ACR_SRC_P1 = 2;
  localparam int ACR_SRC_P2A = 3;
  localparam int ACR_SRC_P2B = 4;
  localparam int ACR_SRC_RX512 = 5;
  localparam int ACR_SRC_RX256 = 6;
  localparam int ACR_SRC_SYS1 = 7;
  localparam int ACR_SRC_SYS2 = 8;
  localparam int ACR_SRC_SYS3 = 9;
  localparam int ACR_NSRC = 10;

  // Positions of the halved taps.
  localparam int ACR_HALF_P1 = 0;
  localparam int ACR_HALF_P2A = 1;
  localparam int ACR_HALF_P2B = 2;

  // States of the runt-free switch.
  typedef enum logic [1:0] {
    ACR_FOLLOW,
    ACR_DRAIN,
    ACR_ARM
  } acr_mux_state_t;

endpackage

// ===== rtl/acr_mux_if.sv
`timescale 1ns/1ns
// Carries the candidates, the select and the switched clock of one switch.
interface acr_mux_if #(parameter int SW = 1);
  logic [(1 << SW)-1:0] src;
  logic [SW-1:0] sel;
  logic clk_out;
  logic locked;
  modport mux (input src, input sel, output clk_out, output locked);
  modport user (output src, output sel, input clk_out, input locked);
endinterface

// ===== rtl/acr_glitch_mux.sv
`timescale 1ns/1ns
module acr_glitch_mux
  import acr_pkg::*;
#(
  parameter int SW = 1
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_rst,
  // Candidates, select and switched clock.
  acr_mux_if.mux m
);

  // Select in use, switch state and the switched level.
  logic [SW-1:0] cur_q;
  logic [SW-1:0] cur_d;
  acr_mux_state_t state_q;
  acr_mux_state_t state_d;
  logic out_q;
  logic out_d;

  // Level of the source in use and whether software asked for another.
  wire logic cur_src = m.src[cur_q];
  wire logic changed = (m.sel != cur_q);

  assign m.clk_out = out_q;
  assign m.locked = (state_q == ACR_FOLLOW) && !changed;

  // Switching never cuts a high phase short nor starts one mid-way: the old
  // source is followed down to low, then the output parks low until the new
  // source is low too, so the first high phase seen is a whole one.
  always_comb begin
    state_d = state_q;
    cur_d = cur_q;
    out_d = out_q;
    unique case (state_q)
      // Follow the selected source.
      ACR_FOLLOW: begin
        out_d = cur_src;
        if (changed) begin
          state_d = ACR_DRAIN;
        end
      end
      // R13 runt-free switch: the output may fall but never rise here.
      ACR_DRAIN: begin
        out_d = out_q & cur_src;
        if (!out_d) begin
          cur_d = m.sel;
          state_d = ACR_ARM;
        end
      end
      // Hold low until the new source is low.
      ACR_ARM: begin
        out_d = 1'b0;
        if (!cur_src) begin
          state_d = ACR_FOLLOW;
        end
      end
      // The unused state code recovers to following.
      default: begin
        state_d = ACR_FOLLOW;
      end
    endcase
  end

  // State registers.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= ACR_FOLLOW;
      cur_q <= '0;
      out_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cur_q <= cur_d;
      out_q <= out_d;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  a_drain_no_rise: assert property (state_q == ACR_DRAIN |=> !$rose(out_q)) // R13
    else $error("Switched clock rose while draining.");
  a_follow_tracks: assert property ($past(m.locked) |-> out_q == $past(cur_src)) // R13
    else $error("Switched clock does not track its source.");

endmodule

// ===== tb/acr_tb_top.sv
`timescale 1ns/1ns
module acr_tb_top;
  import acr_pkg::*;
  // Bench drive of clock, reset and register port.
  logic i_clk, i_rst, i_reg_wr, i_reg_rd;
  logic [6:0] i_reg_addr;
  logic [7:0] i_reg_wdata, o_reg_rdata;
  logic o_reg_rvalid, o_receiver_power_down;
  // Candidates, routed clocks and pin enables.
  logic [9:0] src_q;
  logic [10:0] outs;
  logic [2:0] oe;
  int err_count = 0;
  int cmp_count = 0;
  // Distinct half periods, so an edge count names the source.
  int hp [10] = '{2, 3, 5, 7, 11, 13, 17, 4, 6, 8};
  // Counting window; long enough that half periods 13 and 14 give counts outside each other's tolerance.
  localparam int WIN = 1000;
  int cnt [10] = '{default: 0};
  int rises [11];
  logic [7:0] model [int];

  acr_top u_acr_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .i_crystal_input(src_q[0]), .i_master_clock_input(src_q[1]), .i_pll_one_rate(src_q[2]),
    .i_pll_two_rate_a(src_q[3]), .i_pll_two_rate_b(src_q[4]), .i_rx_pll_512fs(src_q[5]),
    .i_rx_pll_256fs(src_q[6]), .i_sys_one_src(src_q[7]), .i_sys_two_src(src_q[8]),
    .i_sys_three_pll_src(src_q[9]), .o_dac_core_clk(outs[0]), .o_adc_core_clk(outs[1]),
    .o_first_internal_clock(outs[2]), .o_second_internal_clock(outs[3]),
    .o_internal_pll_clock_one(outs[4]), .o_internal_pll_clock_two(outs[5]),
    .o_pll_one_ref_clk(outs[6]), .o_pll_two_ref_clk(outs[7]), .o_system_clock_out_one(outs[8]),
    .o_system_clock_out_one_oe(oe[2]), .o_system_clock_out_two(outs[9]),
    .o_system_clock_out_two_oe(oe[1]), .o_system_clock_out_three(outs[10]),
    .o_system_clock_out_three_oe(oe[0]), .o_receiver_power_down(o_receiver_power_down)
  );

  // Free running bench clock.
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // Each candidate toggles after its half period, off the sampling edge.
  always @(negedge i_clk) begin
    for (int i = 0; i < 10; i++) begin
      cnt[i] = cnt[i] + 1;
      if (cnt[i] >= hp[i]) begin
        cnt[i] = 0;
        src_q[i] <= ~src_q[i];
      end
    end
  end

  task automatic results();
    if (err_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic cmp8(string nm, logic [7:0] exp, logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // A zero half period means a stopped clock, which must show no rising edge at all.
  task automatic cmp_rate(string nm, int half, int got);
    int exp;
    int tol;
    exp = (half == 0) ? 0 : WIN / (2 * half);
    tol = (half == 0) ? 0 : 1;
    cmp_count++;
    if (got > exp + tol || got < exp - tol) begin
      err_count++;
      $display("[ERR] %s expected %0d rises seen %0d", nm, exp, got);
    end
  endtask

  function automatic logic [7:0] mask(logic [6:0] a);
    case (a)
      ACR_ADDR_PLL_CTRL1: return ACR_MASK_PLL_CTRL1;
      ACR_ADDR_CONV: return ACR_MASK_CONV;
      ACR_ADDR_TAP: return ACR_MASK_TAP;
      ACR_ADDR_REF: return ACR_MASK_REF;
      ACR_ADDR_GATE: return ACR_MASK_GATE;
      default: return 8'h00;
    endcase
  endfunction

  task automatic reg_wr(logic [6:0] a, logic [7:0] d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(negedge i_clk);
    i_reg_wr = 1'b0;
    model[a] = d & mask(a);
  endtask

  task automatic reg_rd(logic [6:0] a);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(negedge i_clk);
    i_reg_rd = 1'b0;
    cmp8("rvalid", 8'h01, {7'h00, o_reg_rvalid});
    cmp8("rdata", model[a], o_reg_rdata);
  endtask

  // Half period selected by a converter or internal clock code.
  function automatic int sel_hp(logic [2:0] code, int h1, int h2);
    case (code)
      3'h1: return hp[1];
      3'h2: return h1;
      3'h3: return h2;
      3'h4: return hp[5];
      3'h5: return hp[6];
      default: return hp[0];
    endcase
  endfunction

  // Counts rising edges of every routed clock over a fixed window.
  task automatic measure();
    logic [10:0] prev;
    prev = outs;
    for (int i = 0; i < 11; i++) rises[i] = 0;
    repeat (WIN) begin
      @(negedge i_clk);
      for (int i = 0; i < 11; i++) if (outs[i] === 1'b1 && prev[i] === 1'b0) rises[i]++;
      prev = outs;
    end
  endtask

  task automatic check_routing();
    logic [7:0] cv, tp, rf, gt, pl;
    int h1, h2, h3;
    cv = model[ACR_ADDR_CONV];
    tp = model[ACR_ADDR_TAP];
    rf = model[ACR_ADDR_REF];
    gt = model[ACR_ADDR_GATE];
    pl = model[ACR_ADDR_PLL_CTRL1];
    h1 = tp[0] ? 2 * hp[2] : hp[2];
    h2 = (tp[1] ? 2 : 1) * (tp[2] ? hp[4] : hp[3]);
    h3 = (pl[7:6] == 2'h0) ? hp[9] : (pl[7:6] == 2'h3) ? (pl[0] ? hp[6] : hp[5]) : 0;
    // Long enough for any switch to drain the old source and arm the new one.
    repeat (80) @(negedge i_clk);
    measure();
    cmp_rate("dac_clk", sel_hp(cv[7:5], h1, h2), rises[0]);
    cmp_rate("adc_clk", sel_hp(cv[4:2], h1, h2), rises[1]);
    cmp_rate("first_int", sel_hp({1'b0, tp[4:3]}, h1, h2), rises[2]);
    cmp_rate("second_int", sel_hp({1'b0, cv[1:0]}, h1, h2), rises[3]);
    cmp_rate("pll_one_int", h1, rises[4]);
    cmp_rate("pll_two_int", h2, rises[5]);
    cmp_rate("pll_one_ref", rf[6] ? hp[1] : hp[0], rises[6]);
    cmp_rate("pll_two_ref", rf[7] ? hp[1] : hp[0], rises[7]);
    cmp_rate("sys_one", gt[2] ? 0 : hp[7], rises[8]);
    cmp_rate("sys_two", gt[1] ? 0 : hp[8], rises[9]);
    cmp_rate("sys_three", gt[0] ? 0 : h3, rises[10]);
    cmp8("oe", {5'h00, ~gt[2:0]}, {5'h00, oe});
    cmp8("gated_low", 8'h00, {5'h00, outs[8] & gt[2], outs[9] & gt[1], outs[10] & gt[0]});
    cmp8("power_down", {7'h00, gt[5]}, {7'h00, o_receiver_power_down});
  endtask

  initial begin
    logic [2:0] c;
    logic [31:0] r;
    i_rst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_reg_addr = 7'h00;
    i_reg_wdata = 8'h00;
    src_q = 10'h000;
    r = $urandom(32'h99A95C3E);
    for (int a = 8'h74; a <= 8'h7B; a++) model[a] = 8'h00;
    repeat (6) @(negedge i_clk);
    i_rst = 1'b0;
    // Reset contents and the default routing from the crystal.
    for (int a = 8'h74; a <= 8'h7B; a++) reg_rd(a[6:0]);
    check_routing();
    // Reserved bits and unmapped offsets, all ones and then random data.
    for (int a = 8'h74; a <= 8'h7B; a++) begin
      reg_wr(a[6:0], 8'hFF);
      reg_rd(a[6:0]);
      reg_wr(a[6:0], 8'($urandom));
      reg_rd(a[6:0]);
    end
    // Every select code at least once, with random reserved and gate bits and random PLL one reference and recovered clock rate bits.
    for (int k = 0; k < 8; k++) begin
      c = k[2:0];
      r = $urandom;
      reg_wr(ACR_ADDR_CONV, {c, ~c, c[1:0]});
      reg_wr(ACR_ADDR_TAP, {r[7:5], ~c[1:0], c[2:1], c[0]});
      reg_wr(ACR_ADDR_REF, {c[0], r[0], r[6:1]});
      reg_wr(ACR_ADDR_GATE, r[15:8]);
      reg_wr(ACR_ADDR_PLL_CTRL1, {c[1], c[0] ^ c[2], r[21:16]});
      check_routing();
      reg_rd(ACR_ADDR_GATE);
    end
    results();
  end

  // Watchdog sized well beyond the roughly ten thousand cycles of the run.
  initial begin
    repeat (20000) @(posedge i_clk);
    err_count++;
    results();
  end
endmodule
